/* hw/wide_timer_params.svh */
// register offsets, field positions, reset values and divider widths of the 16-bit timer
// assumes inclusion by bare name from the timer module
`ifndef WIDE_TIMER_PARAMS_SVH
`define WIDE_TIMER_PARAMS_SVH

// ==========================================
// register offsets, instance 0 and instance 1
`define WT_CTRL_OFS_0 8'h01
`define WT_REFH_OFS_0 8'h02
`define WT_REFL_OFS_0 8'h03
`define WT_CNTH_OFS_0 8'h04
`define WT_CNTL_OFS_0 8'h05
`define WT_CTRL_OFS_1 8'h0A
`define WT_REFH_OFS_1 8'h0B
`define WT_REFL_OFS_1 8'h0C
`define WT_CNTH_OFS_1 8'h0D
`define WT_CNTL_OFS_1 8'h0E
`define WT_PEND_OFS 8'h10

// ==========================================
// control register fields and reset values
`define WT_CTRL_RESET 8'h00
`define WT_CSEL_MSB 7
`define WT_CSEL_LSB 5
`define WT_MODE_MSB 4
`define WT_MODE_LSB 3
`define WT_CLR_BIT 2
`define WT_MIE_BIT 1
`define WT_OIE_BIT 0
`define WT_REF_RESET 16'hFFFF
`define WT_CNT_MAX 16'hFFFF
`define WT_CAP_PIN_SEL 2'h0

// ==========================================
// pending flag positions per instance
`define WT_PEND_OVF_0 2
`define WT_PEND_MC_0 3
`define WT_PEND_OVF_1 4
`define WT_PEND_MC_1 5

// ==========================================
// interrupt level and vectors
`define WT_IRQ_LEVEL 3'h3
`define WT_VEC_OVF_0 8'hDA
`define WT_VEC_MC_0 8'hD8
`define WT_VEC_OVF_1 8'hDE
`define WT_VEC_MC_1 8'hDC

// ==========================================
// prescaler: low bits that must all be ones for a tick
`define WT_DIV_1024_W 10
`define WT_DIV_256_W 8
`define WT_DIV_64_W 6
`define WT_DIV_8_W 3

`endif

/* hw/wide_timer_pkg.sv */
// types shared by the 16-bit timer: clock selection and operating mode
// assumes the params header is on the include path
package wide_timer_pkg;

  // ==========================================
  // clock select field
  typedef enum logic [2:0] {
    CSEL_DIV1024 = 3'b000,
    CSEL_DIV256 = 3'b001,
    CSEL_DIV64 = 3'b010,
    CSEL_DIV8 = 3'b011,
    CSEL_DIV1 = 3'b100,
    CSEL_EXT_FALL = 3'b101,
    CSEL_EXT_RISE = 3'b110,
    CSEL_STOP = 3'b111
  } clk_sel_t;

  // ==========================================
  // operating mode field
  typedef enum logic [1:0] {
    MODE_INTERVAL = 2'b00,
    MODE_CAP_RISE = 2'b01,
    MODE_CAP_FALL = 2'b10,
    MODE_PWM = 2'b11
  } timer_mode_t;

endpackage : wide_timer_pkg

/* hw/pin_edge_sync.sv */
// two-flop synchroniser for one pin with rising and falling edge pulses
// assumes the pin is asynchronous to clk_sys
`timescale 1ns/10ps
module pin_edge_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // pin and edges
  input wire logic pin_in,
  output logic rise_pulse,
  output logic fall_pulse
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // ==========================================
  // synchroniser; only sync_ff reads meta_ff
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign rise_pulse = sync_ff & ~last_ff;
  assign fall_pulse = ~sync_ff & last_ff;

endmodule : pin_edge_sync

/* hw/wide_timer.sv */
// one 16-bit timer/counter with prescaler, interval, capture and pwm modes
// assumes a byte register port on clk_sys and pins that are asynchronous to it
//
// Notes on behaviour
// - bits 7:5 pick prescaler, external edge, stop
// - bits 4:3 pick interval, capture, pwm
// - writing one to bit 2 clears counter
// - bit 1 gates match/capture request
// - bit 0 gates overflow request
// - reset makes control zero
// - overflow flag cleared by service or zero-write
// - match flag set per event, cleared by software
// - instance 0 vectors DAh and D8h, level three
// - instance 1 vectors DEh and DCh, level three
// - interval match requests interrupt, resets counter
// - interval match inverts output pin
// - pwm counter runs free through FFFFh
// - pwm output high while reference exceeds count
// - pwm drives the same output pin
// - capture edge copies counter into reference
// - capture mode still raises overflow
// - capture pin used only when select is 00
// - 16-bit counter, comparator, split reference register
`timescale 1ns/10ps
`include "wide_timer_params.svh"
module wide_timer #(
  parameter bit INSTANCE_ID = 1'b0,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  // pins and port selection
  input wire logic ext_count_clock_in,
  input wire logic capture_edge_in,
  input wire logic [1:0] port_function_select,
  output logic match_toggle_out,
  // interrupt requests
  input wire logic wrap_irq_serviced,
  output logic counter_wrap_irq,
  output logic match_capture_irq,
  output logic [2:0] irq_level_three,
  output logic [7:0] wrap_vector,
  output logic [7:0] match_vector
);

  // ==========================================
  // per-instance constants
  localparam logic [7:0] CTRL_OFS = INSTANCE_ID ? `WT_CTRL_OFS_1 : `WT_CTRL_OFS_0;
  localparam logic [7:0] REFH_OFS = INSTANCE_ID ? `WT_REFH_OFS_1 : `WT_REFH_OFS_0;
  localparam logic [7:0] REFL_OFS = INSTANCE_ID ? `WT_REFL_OFS_1 : `WT_REFL_OFS_0;
  localparam logic [7:0] CNTH_OFS = INSTANCE_ID ? `WT_CNTH_OFS_1 : `WT_CNTH_OFS_0;
  localparam logic [7:0] CNTL_OFS = INSTANCE_ID ? `WT_CNTL_OFS_1 : `WT_CNTL_OFS_0;
  localparam int PEND_OVF = INSTANCE_ID ? `WT_PEND_OVF_1 : `WT_PEND_OVF_0;
  localparam int PEND_MC = INSTANCE_ID ? `WT_PEND_MC_1 : `WT_PEND_MC_0;
  localparam logic [7:0] VEC_OVF = INSTANCE_ID ? `WT_VEC_OVF_1 : `WT_VEC_OVF_0;
  localparam logic [7:0] VEC_MC = INSTANCE_ID ? `WT_VEC_MC_1 : `WT_VEC_MC_0;
  localparam logic [CNT_W-1:0] CNT_MAX = `WT_CNT_MAX;
  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  // ==========================================
  // state
  logic [7:0] ctrl_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] ref_ff;
  logic [`WT_DIV_1024_W-1:0] div_ff;
  logic ovf_pend_ff;
  logic mc_pend_ff;
  logic out_ff;
  logic toggle_ff;
  logic wrap_irq_ff;
  logic mc_irq_ff;
  logic [7:0] rdata_ff;

  // ==========================================
  // register decode
  wire ctrl_wr = reg_wr && (reg_addr == CTRL_OFS);
  wire refh_wr = reg_wr && (reg_addr == REFH_OFS);
  wire refl_wr = reg_wr && (reg_addr == REFL_OFS);
  wire pend_wr = reg_wr && (reg_addr == `WT_PEND_OFS);
  wire clear_wr = ctrl_wr && reg_wdata[`WT_CLR_BIT];

  wire [2:0] csel_bits = ctrl_ff[`WT_CSEL_MSB:`WT_CSEL_LSB];
  wire [1:0] mode_bits = ctrl_ff[`WT_MODE_MSB:`WT_MODE_LSB];
  wide_timer_pkg::clk_sel_t csel;
  wide_timer_pkg::timer_mode_t mode;
  assign csel = wide_timer_pkg::clk_sel_t'(csel_bits);
  assign mode = wide_timer_pkg::timer_mode_t'(mode_bits);

  wire is_interval = (mode == wide_timer_pkg::MODE_INTERVAL);
  wire is_pwm = (mode == wide_timer_pkg::MODE_PWM);
  wire is_cap_rise = (mode == wide_timer_pkg::MODE_CAP_RISE);
  wire is_cap_fall = (mode == wide_timer_pkg::MODE_CAP_FALL);

  // ==========================================
  // pin synchronisers
  // two flops per pin; an edge reaches the counter three clocks after the pin moves
  wire ext_rise;
  wire ext_fall;
  wire cap_rise;
  wire cap_fall;

  pin_edge_sync u_ext_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin_in(ext_count_clock_in),
    .rise_pulse(ext_rise),
    .fall_pulse(ext_fall)
  );

  pin_edge_sync u_cap_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin_in(capture_edge_in),
    .rise_pulse(cap_rise),
    .fall_pulse(cap_fall)
  );

  // ==========================================
  // prescaler: one free divider, taps give each rate as a one-cycle enable
  // the divider never restarts, so the first interval after a rate change may be short
  wire tap_1024 = &div_ff[`WT_DIV_1024_W-1:0];
  wire tap_256 = &div_ff[`WT_DIV_256_W-1:0];
  wire tap_64 = &div_ff[`WT_DIV_64_W-1:0];
  wire tap_8 = &div_ff[`WT_DIV_8_W-1:0];

  wire tick = (csel == wide_timer_pkg::CSEL_DIV1024) ? tap_1024 :
              (csel == wide_timer_pkg::CSEL_DIV256) ? tap_256 :
              (csel == wide_timer_pkg::CSEL_DIV64) ? tap_64 :
              (csel == wide_timer_pkg::CSEL_DIV8) ? tap_8 :
              (csel == wide_timer_pkg::CSEL_DIV1) ? 1'b1 :
              (csel == wide_timer_pkg::CSEL_EXT_FALL) ? ext_fall :
              (csel == wide_timer_pkg::CSEL_EXT_RISE) ? ext_rise :
              1'b0;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  // ==========================================
  // comparator and events
  wire at_ref = (cnt_ff == ref_ff);
  wire at_max = (cnt_ff == CNT_MAX);
  // a clear write beats a tick in the same cycle, so counting restarts from a true zero
  wire step = tick && !clear_wr;
  // a match only resets the counter in interval mode
  wire match_evt = step && at_ref && (is_interval || is_pwm);
  // at all ones an interval match resets the counter, so that tick is no wrap
  wire wrap_evt = step && at_max && !(is_interval && at_ref);
  // the capture gate only opens while the port routes the pin to the timer
  wire cap_src_ok = (port_function_select == `WT_CAP_PIN_SEL);
  wire capture_evt = cap_src_ok && ((is_cap_rise && cap_rise) || (is_cap_fall && cap_fall));
  wire mc_evt = match_evt || capture_evt;

  wire [CNT_W-1:0] nxt_cnt = clear_wr ? '0 :
                             !tick ? cnt_ff :
                             (is_interval && at_ref) ? '0 :
                             cnt_ff + CNT_ONE;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // ==========================================
  // control register; bit 2 acts on write and reads back zero
  // keeping the strobe out of the flop means a read-modify-write never clears twice
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= `WT_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_ff <= reg_wdata & ~(8'h01 << `WT_CLR_BIT);
    end
  end

  // ==========================================
  // reference register: capture beats a bus write in the same cycle
  // all ones at reset, so an unprogrammed interval timer spans the full range
  wire [CNT_W-1:0] nxt_ref = capture_evt ? cnt_ff :
                             refh_wr ? {reg_wdata, ref_ff[7:0]} :
                             refl_wr ? {ref_ff[CNT_W-1:8], reg_wdata} :
                             ref_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ref_ff <= `WT_REF_RESET;
    end else begin
      ref_ff <= nxt_ref;
    end
  end

  // ==========================================
  // pending flags: a new event wins over any clear in the same cycle
  // so a polling loop never loses an event that lands on its own clear
  // service clears only the overflow flag; the match flag waits for software
  wire ovf_sw_clr = pend_wr && !reg_wdata[PEND_OVF];
  wire mc_sw_clr = pend_wr && !reg_wdata[PEND_MC];
  wire nxt_ovf_pend = wrap_evt || (ovf_pend_ff && !ovf_sw_clr && !wrap_irq_serviced);
  wire nxt_mc_pend = mc_evt || (mc_pend_ff && !mc_sw_clr);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ovf_pend_ff <= 1'b0;
      mc_pend_ff <= 1'b0;
    end else begin
      ovf_pend_ff <= nxt_ovf_pend;
      mc_pend_ff <= nxt_mc_pend;
    end
  end

  // ==========================================
  // requests: pending is kept for polling even while the request is gated
  // the request follows the next pending value, so it rises on the edge that sets the flag
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrap_irq_ff <= 1'b0;
      mc_irq_ff <= 1'b0;
    end else begin
      wrap_irq_ff <= nxt_ovf_pend && ctrl_ff[`WT_OIE_BIT];
      mc_irq_ff <= nxt_mc_pend && ctrl_ff[`WT_MIE_BIT];
    end
  end

  // ==========================================
  // output pin: interval toggle or pwm level on one pin
  // capture modes leave the pin at its last interval level
  // the pwm level lags the count by one cycle because the pin comes from a flop
  wire nxt_toggle = match_evt && is_interval ? !toggle_ff : toggle_ff;
  wire pwm_level = (ref_ff > cnt_ff);
  wire nxt_out = is_pwm ? pwm_level : nxt_toggle;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      toggle_ff <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      toggle_ff <= nxt_toggle;
      out_ff <= nxt_out;
    end
  end

  // ==========================================
  // read data, registered; unmapped addresses read zero
  // the pending byte is shared: each instance fills only its own two bits
  // and the system ors the read buses of both instances
  wire [7:0] pend_rd = (8'(ovf_pend_ff) << PEND_OVF) | (8'(mc_pend_ff) << PEND_MC);
  wire [7:0] nxt_rdata = (reg_addr == CTRL_OFS) ? ctrl_ff :
                         (reg_addr == REFH_OFS) ? ref_ff[CNT_W-1:8] :
                         (reg_addr == REFL_OFS) ? ref_ff[7:0] :
                         (reg_addr == CNTH_OFS) ? cnt_ff[CNT_W-1:8] :
                         (reg_addr == CNTL_OFS) ? cnt_ff[7:0] :
                         (reg_addr == `WT_PEND_OFS) ? pend_rd :
                         8'h00;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================
  // fixed interrupt identity, held in flops so every output is registered
  // both branches load constants, so the values also stand during reset
  logic [2:0] level_ff;
  logic [7:0] vec_ovf_ff;
  logic [7:0] vec_mc_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      level_ff <= `WT_IRQ_LEVEL;
      vec_ovf_ff <= VEC_OVF;
      vec_mc_ff <= VEC_MC;
    end else begin
      level_ff <= `WT_IRQ_LEVEL;
      vec_ovf_ff <= VEC_OVF;
      vec_mc_ff <= VEC_MC;
    end
  end

  // ==========================================
  // outputs
  assign reg_rdata = rdata_ff;
  assign match_toggle_out = out_ff;
  assign counter_wrap_irq = wrap_irq_ff;
  assign match_capture_irq = mc_irq_ff;
  assign irq_level_three = level_ff;
  assign wrap_vector = vec_ovf_ff;
  assign match_vector = vec_mc_ff;

endmodule : wide_timer

/* test/wide_timer_monitor.sv */
// checker for one timer: vectors, control readback, interrupt gates, output pin
// assumes one clk_sys domain with arst_n as its reset
`timescale 1ns/10ps
module wide_timer_monitor #(
  parameter bit INSTANCE_ID = 1'b0,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  // pin and requests
  input wire logic match_toggle_out,
  input wire logic counter_wrap_irq,
  input wire logic match_capture_irq,
  input wire logic [2:0] irq_level_three,
  input wire logic [7:0] wrap_vector,
  input wire logic [7:0] match_vector
);
  // ==========================================
  // control shadow and quiet time since the last write
  logic [7:0] ctrl_ff;
  logic [1:0] quiet_ff;
  wire logic [7:0] ctrl_ofs = INSTANCE_ID ? 8'h0A : 8'h01;
  // three quiet edges let any write's side effects settle before gates are judged
  wire logic calm = quiet_ff == 2'h3;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= 8'h00;
      quiet_ff <= 2'h0;
    end else begin
      quiet_ff <= reg_wr ? 2'h0 : quiet_ff + {1'b0, quiet_ff != 2'h3};
      if (reg_wr && reg_addr == ctrl_ofs)
        ctrl_ff <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // assertions
  a_vector_codes: assert property (
    wrap_vector == (INSTANCE_ID ? 8'hDE : 8'hDA) && match_vector == (INSTANCE_ID ? 8'hDC : 8'hD8))
    else $error("bad vector");
  a_level_three: assert property (irq_level_three == 3'h3)
    else $error("bad level");
  a_ctrl_readback: assert property (
    reg_wr && reg_addr == ctrl_ofs ##1 (!reg_wr && reg_addr == ctrl_ofs)[*2]
    |=> reg_rdata == ($past(reg_wdata, 3) & 8'hFB)) else $error("control readback wrong");
  a_unmapped_zero: assert property (reg_addr == 8'h3F ##1 reg_addr == 8'h3F |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_wrap_gate: assert property (calm && !ctrl_ff[0] |-> !counter_wrap_irq)
    else $error("overflow request while disabled");
  a_match_gate: assert property (calm && !ctrl_ff[1] |-> !match_capture_irq)
    else $error("match request while disabled");
  a_toggle_with_irq: assert property (
    calm && ctrl_ff[4:3] == 2'b00 && ctrl_ff[1] && $changed(match_toggle_out) |-> match_capture_irq)
    else $error("toggle without match request");
  a_stop_hold: assert property (
    calm && ctrl_ff[7:5] == 3'b111 && ctrl_ff[4:3] == 2'b00 |-> $stable(match_toggle_out))
    else $error("output moved while stopped");
  c_match_irq: cover property (match_capture_irq);
  c_wrap_irq: cover property (counter_wrap_irq);
  c_pwm_rise: cover property (ctrl_ff[4:3] == 2'b11 && $rose(match_toggle_out));
endmodule : wide_timer_monitor

bind wide_timer wide_timer_monitor #(.INSTANCE_ID(INSTANCE_ID), .CNT_W(CNT_W)) wide_timer_monitor_inst (
  .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rdata(reg_rdata), .match_toggle_out(match_toggle_out), .counter_wrap_irq(counter_wrap_irq),
  .match_capture_irq(match_capture_irq), .irq_level_three(irq_level_three), .wrap_vector(wrap_vector),
  .match_vector(match_vector));

/* test/timer_pin_model.sv */
// board-side model of the timer pins: external count clock and capture input
// assumes the bench calls its tasks; both pins idle low
`timescale 1ns/10ps
module timer_pin_model (
  // clock
  input wire logic clk_sys,
  // pins toward the timer
  output logic ext_count_clock_in,
  output logic capture_edge_in
);
  initial begin
    ext_count_clock_in = 1'b0;
    capture_edge_in = 1'b0;
  end
  // each level stands 4 cycles so the two-flop synchroniser cannot miss it
  task automatic clk_pulses(input int cnt);
    repeat (cnt) begin
      @(posedge clk_sys);
      ext_count_clock_in <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_count_clock_in <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask : clk_pulses
  task automatic cap_edge(input logic lvl);
    @(posedge clk_sys);
    capture_edge_in <= lvl;
    repeat (4) @(posedge clk_sys);
  endtask : cap_edge
endmodule : timer_pin_model

/* test/tb_sixteen_bit_timer_capture_pwm.sv */
// bench for the 16-bit timer: registers, prescaler taps, pins, capture, pwm
// assumes instance 0 offsets and the pin model on the external pins
`timescale 1ns/10ps
module tb_sixteen_bit_timer_capture_pwm;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic wrap_irq_serviced = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [1:0] port_function_select = 2'h0;
  logic [7:0] reg_rdata;
  logic [7:0] reg_rdata_1, wrap_vector, match_vector, wrap_vec_1, match_vec_1;
  logic [2:0] irq_level_three, level_1;
  logic out_1, wrap_irq_1, mc_irq_1;
  logic ext_count_clock_in, capture_edge_in, match_toggle_out, counter_wrap_irq, match_capture_irq;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  int divs[5] = '{1024, 256, 64, 8, 1};
  always #20 clk_sys = ~clk_sys;
  wide_timer #(.INSTANCE_ID(1'b0)) wide_timer_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .ext_count_clock_in(ext_count_clock_in), .capture_edge_in(capture_edge_in),
    .port_function_select(port_function_select), .match_toggle_out(match_toggle_out),
    .wrap_irq_serviced(wrap_irq_serviced), .counter_wrap_irq(counter_wrap_irq),
    .match_capture_irq(match_capture_irq), .irq_level_three(irq_level_three), .wrap_vector(wrap_vector),
    .match_vector(match_vector));
  // second instance shares the bus and pins; from its first control write it is stopped in interval mode so the pins never reach it
  wide_timer #(.INSTANCE_ID(1'b1)) wide_timer_inst_1 (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata_1), .ext_count_clock_in(ext_count_clock_in), .capture_edge_in(capture_edge_in),
    .port_function_select(port_function_select), .match_toggle_out(out_1),
    .wrap_irq_serviced(wrap_irq_serviced), .counter_wrap_irq(wrap_irq_1), .match_capture_irq(mc_irq_1),
    .irq_level_three(level_1), .wrap_vector(wrap_vec_1), .match_vector(match_vec_1));
  timer_pin_model timer_pin_model_inst (
    .clk_sys(clk_sys), .ext_count_clock_in(ext_count_clock_in), .capture_edge_in(capture_edge_in));
  // ==========================================
  // access and compare tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    repeat (3) @(posedge clk_sys);
    #1 chk({8'h00, reg_rdata | reg_rdata_1}, {8'h00, exp});
  endtask : rd
  // skips the partial first interval, then counts cycles between two toggles
  task automatic tog_period();
    logic lvl;
    for (int k = 0; k < 2; k++) begin
      #1 lvl = match_toggle_out;
      n = 0;
      while (match_toggle_out === lvl && n < 2100) begin
        @(posedge clk_sys);
        #1 n++;
      end
    end
  endtask : tog_period
  task automatic complete_run();
    $display("tests=%0d failures=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      complete_run();
    end
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(8'h01, 8'h00);
    rd(8'h03, 8'hFF);
    rd(8'h3F, 8'h00);
    chk(16'(irq_level_three), 16'h0003);
    chk(16'(wrap_vector), 16'h00DA);
    chk(16'(match_vector), 16'h00D8);
    chk(16'(level_1), 16'h0003);
    chk(16'(wrap_vec_1), 16'h00DE);
    chk(16'(match_vec_1), 16'h00DC);
    rd(8'h0A, 8'h00);
    wr(8'h0A, 8'hE7);
    rd(8'h0A, 8'hE3);
    for (int i = 0; i < 8; i++) begin
      wr(8'h01, {i[2:0], i[1:0], 3'b111});
      rd(8'h01, {i[2:0], i[1:0], 3'b011});
    end
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h00);
    foreach (divs[k]) begin
      wr(8'h01, {k[2:0], 5'b00100});
      tog_period();
      chk(16'(n), 16'(divs[k]));
    end
    wr(8'h03, 8'h03);
    wr(8'h10, 8'h00);
    wr(8'h01, 8'h84);
    tog_period();
    chk(16'(n), 16'h0004);
    chk(16'(match_capture_irq), 16'h0000);
    rd(8'h10, 8'h08);
    wr(8'h01, 8'h82);
    tog_period();
    chk(16'(match_capture_irq), 16'h0001);
    wr(8'h01, 8'hE2);
    wr(8'h10, 8'h00);
    rd(8'h10, 8'h00);
    chk(16'(match_capture_irq), 16'h0000);
    wr(8'h01, 8'hE6);
    rd(8'h05, 8'h00);
    rd(8'h04, 8'h00);
    wr(8'h01, 8'hAC);
    timer_pin_model_inst.clk_pulses(3);
    rd(8'h05, 8'h03);
    wr(8'h01, 8'hCC);
    timer_pin_model_inst.clk_pulses(6);
    wr(8'h10, 8'h00);
    timer_pin_model_inst.cap_edge(1'b1);
    rd(8'h03, 8'h06);
    rd(8'h10, 8'h08);
    wr(8'h01, 8'hD0);
    port_function_select <= 2'h1;
    timer_pin_model_inst.clk_pulses(2);
    timer_pin_model_inst.cap_edge(1'b0);
    rd(8'h03, 8'h06);
    port_function_select <= 2'h0;
    timer_pin_model_inst.cap_edge(1'b1);
    timer_pin_model_inst.cap_edge(1'b0);
    rd(8'h03, 8'h08);
    rd(8'h05, 8'h08);
    wr(8'h01, 8'h9D);
    wr(8'h03, 8'h10);
    n = 0;
    while (counter_wrap_irq !== 1'b1 && n < 70000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(16'(counter_wrap_irq), 16'h0001);
    n = 0;
    while (match_toggle_out !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1 n++;
    end
    n = 0;
    while (match_toggle_out === 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(16'(n), 16'h0010);
    @(posedge clk_sys);
    wrap_irq_serviced <= 1'b1;
    @(posedge clk_sys);
    wrap_irq_serviced <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk(16'(counter_wrap_irq), 16'h0000);
    chk(16'({out_1, wrap_irq_1, mc_irq_1}), 16'h0000);
    complete_run();
  end
endmodule : tb_sixteen_bit_timer_capture_pwm
